// file: src/dcvi_pkg.sv
// Package with the constants and types of the interrupt daisy chain.
`default_nettype none
package dcvi_pkg;

  // ----------------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------------
  localparam int NSRC = 3;
  localparam int NSUB = 8;
  localparam logic [3:0] TMR_DIV_LAST = 4'hF;

  // ----------------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_VBASE = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [3:0] PAGE_CH    = 4'h1;
  localparam logic [3:0] PAGE_PCFG  = 4'h2;
  localparam logic [3:0] PAGE_PDAT  = 4'h3;
  localparam int CH_EN     = 0;
  localparam int CH_IE     = 1;
  localparam int CH_CNT    = 2;
  localparam int CH_TC_LSB = 8;
  localparam int PP_IE        = 2;
  localparam int PP_MASK_LSB  = 8;
  localparam int PP_MATCH_LSB = 16;
  localparam int PP_VEC_LSB   = 25;
  localparam logic [3:0][15:0] CH_CFG_RST =
    {16'h0000, 16'h0004, 16'h0000, 16'h0000};
  localparam logic [7:0] RETURN_FROM_INTERRUPT_INSTRUCTION_B0  = 8'hED;
  localparam logic [7:0] RETURN_FROM_INTERRUPT_INSTRUCTION_B1  = 8'h4D;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_OUT = 2'b00, PM_IN = 2'b01, PM_BIDIR = 2'b10, PM_BIT = 2'b11
  } dcvi_pmode_t;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_ED = 1'b1} dcvi_return_from_interrupt_instruction_t;
  typedef struct packed {
    logic [7:0]  awaddr;  logic awvalid;
    logic [31:0] wdata;   logic [3:0] wstrb; logic wvalid;
    logic        bready;
    logic [7:0]  araddr;  logic arvalid; logic rready;
  } dcvi_axi_req_t;
  typedef struct packed {
    logic awready; logic wready;
    logic bvalid;  logic [1:0] bresp;
    logic arready; logic rvalid;
    logic [31:0] rdata; logic [1:0] rresp;
  } dcvi_axi_rsp_t;
  typedef struct packed {
    logic [7:0] cnt; logic prev; logic en; logic evt;
  } dcvi_chan_st_t;
  typedef struct packed {
    logic prev_stb; logic prev_match; logic [7:0] data; logic evt;
  } dcvi_port_st_t;
  typedef struct packed {
    dcvi_axi_rsp_t rsp;
    logic aw_hold; logic [7:0] aw_addr;
    logic w_hold;  logic [31:0] wdata; logic [3:0] wstrb;
    logic [4:0] vbase;
    logic [3:0][15:0] ch_cfg;
    logic [3:0][31:0] pp_cfg;
    logic [7:0] ip; logic [2:0] ius; logic [2:0][1:0] code;
    dcvi_return_from_interrupt_instruction_t return_from_interrupt_instruction;
    logic [3:0] div; logic tick;
    logic [39:0] sync1; logic [39:0] sync2;
    logic int_n; logic nmi_n; logic [7:0] vec; logic vec_vld;
  } dcvi_st_t;

endpackage
`default_nettype wire

// file: src/dcvi_chan.sv
// One counter-timer channel: down counter with reload and zero event.
`default_nettype none
module dcvi_chan
  import dcvi_pkg::*;
(
  input  wire logic        clk_i,   // System clock.
  input  wire logic        rst_n_i, // Asynchronous reset, active low.
  input  wire logic [15:0] cfg_i,   // Channel configuration word.
  input  wire logic        tick_i,  // Prescaled timer enable pulse.
  input  wire logic        cin_i,   // Synchronised count input level.
  output logic      [7:0]  cnt_o,   // Current count.
  output logic             evt_o    // Pulse when the count expires.
);

  dcvi_chan_st_t s;
  dcvi_chan_st_t next_s;
  logic          step;
  logic [7:0]    cur;

  // A time constant of zero counts 256 steps. The first enabled cycle
  // starts from the time constant written with the enable, so a new
  // setting is never counted down from a stale reload value.
  always_comb begin
    next_s      = s;
    next_s.evt  = 1'h0;
    next_s.prev = cin_i;
    next_s.en   = cfg_i[CH_EN];
    step = cfg_i[CH_CNT] ? (cin_i & ~s.prev) : tick_i;
    cur  = s.en ? s.cnt : cfg_i[CH_TC_LSB +: 8];
    if (!cfg_i[CH_EN]) begin
      next_s.cnt = cfg_i[CH_TC_LSB +: 8];
    end else if (step) begin
      if (cur == 8'h01) begin
        next_s.cnt = cfg_i[CH_TC_LSB +: 8];
        next_s.evt = 1'h1;
      end else begin
        next_s.cnt = cur - 8'h01;
      end
    end else begin
      next_s.cnt = cur;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cnt_o = s.cnt;
  assign evt_o = s.evt;

endmodule // dcvi_chan
`default_nettype wire

// file: src/dcvi_port.sv
// One parallel port half: byte strobe or status match event.
`default_nettype none
module dcvi_port
  import dcvi_pkg::*;
(
  input  wire logic        clk_i,   // System clock.
  input  wire logic        rst_n_i, // Asynchronous reset, active low.
  input  wire logic [31:0] cfg_i,   // Port configuration word.
  input  wire logic        stb_i,   // Synchronised transfer request.
  input  wire logic [7:0]  stat_i,  // Synchronised peripheral lines.
  output logic      [7:0]  data_o,  // Byte latched on a transfer in input or bidirectional mode.
  output logic             evt_o    // Pulse on a new interrupt cause.
);

  dcvi_port_st_t s;
  dcvi_port_st_t next_s;
  dcvi_pmode_t   mode;
  logic          match;

  always_comb begin
    next_s          = s;
    mode            = dcvi_pmode_t'(cfg_i[1:0]);
    match = ((stat_i ^ cfg_i[PP_MATCH_LSB +: 8])
             & cfg_i[PP_MASK_LSB +: 8]) == 8'h00;
    next_s.prev_stb   = stb_i;
    next_s.prev_match = match;
    next_s.evt        = 1'h0;
    if (mode == PM_BIT) begin
      next_s.evt = match & ~s.prev_match;
    end else if (stb_i && !s.prev_stb) begin
      next_s.evt = 1'h1;
      if (mode != PM_OUT) begin
        next_s.data = stat_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign data_o = s.data;
  assign evt_o  = s.evt;

endmodule // dcvi_port
`default_nettype wire

// file: src/dcvi_chain.sv
// Vectored interrupt daisy chain with counter-timer and two ports.
//
// How it works
// - Three sources share one chain: counter-timer, keyboard port, printer.
// - Fixed priority: counter-timer first, keyboard port, printer last.
// - Lower sources never interrupt higher ones; higher ones may nest.
// - Counter-timer picks its lowest-numbered requesting channel.
// - The priority winner returns an 8-bit vector on acknowledge.
// - Counter-timer vector bits 7..3 are a stored, software-written base.
// - Counter-timer vector bits 2..1 give the winning channel number.
// - Vector bit 0 is always zero for every source.
// - Fetched return-from-interrupt opcodes end the current service.
// - Inside a port unit, port A beats port B.
// - Byte modes interrupt on each new peripheral transfer request.
// - Bit mode interrupts when masked status equals programmed value.
// - Ports A and B each keep their own vector.
// - Printer port behaves as keyboard port, last in chain.
// - Only the maskable interrupt output is used; NMI stays idle.
// - Four counter-timer channels each raise their own interrupt.
// - Channel 2 is set to count vertical sync pulses after reset, but starts disabled.
// - Channels 0, 1 and 3 are set as timers after reset, but start disabled.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`default_nettype none
module dcvi_chain
  import dcvi_pkg::*;
(
  input  wire logic              CLK_SYS_I, // 20 MHz system clock.
  input  wire logic              RST_N_I,   // Async reset, active low.
  input  wire dcvi_axi_req_t     AXI_REQ_I, // AXI4-Lite requests.
  output dcvi_axi_rsp_t          AXI_RSP_O, // AXI4-Lite responses.
  input  wire logic              IACK_I,    // Acknowledge cycle pulse.
  input  wire logic              FETCH_I,   // Opcode fetch strobe.
  input  wire logic [7:0]        DBUS_I,    // Snooped data bus.
  input  wire logic [3:0]        CNT_I,     // Channel count pins.
  input  wire logic [3:0]        STB_I,     // Port transfer requests.
  input  wire logic [3:0][7:0]   PSTAT_I,   // Port peripheral lines.
  output logic                   INT_N_O,   // Maskable interrupt, low.
  output logic                   NMI_N_O,   // Non-maskable, held high.
  output logic [7:0]             VEC_O,     // Interrupt vector.
  output logic                   VEC_VLD_O  // Vector valid pulse.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dcvi_st_t         s;
  dcvi_st_t         next_s;
  logic [3:0]       cnt_s;
  logic [3:0]       stb_s;
  logic [3:0][7:0]  stat_s;
  logic [3:0][7:0]  ch_cnt;
  logic [3:0]       ch_evt;
  logic [3:0][7:0]  pp_data;
  logic [3:0]       pp_evt;
  logic [7:0]       ev;
  logic [2:0]       src_ip;
  logic [2:0]       pin;
  logic [2:0]       req;
  logic [1:0]       win;
  logic             win_any;
  logic [1:0]       sub;
  logic [7:0]       win_vec;
  logic [7:0]       clr;
  logic             return_from_interrupt_instruction;
  logic [31:0]      wmask;
  logic [31:0]      rd;
  logic [1:0]       rresp;

  assign cnt_s  = s.sync2[39:36];
  assign stb_s  = s.sync2[35:32];
  assign stat_s = s.sync2[31:0];

  // ----------------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------------
  // four counting channels
  for (genvar i = 0; i < 4; i++) begin : g_ch
    dcvi_chan u_chan (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RST_N_I),
      .cfg_i   (s.ch_cfg[i]),
      .tick_i  (s.tick),
      .cin_i   (cnt_s[i]),
      .cnt_o   (ch_cnt[i]),
      .evt_o   (ch_evt[i])
    );
  end

  for (genvar i = 0; i < 4; i++) begin : g_pp
    dcvi_port u_port (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RST_N_I),
      .cfg_i   (s.pp_cfg[i]),
      .stb_i   (stb_s[i]),
      .stat_i  (stat_s[i]),
      .data_o  (pp_data[i]),
      .evt_o   (pp_evt[i])
    );
  end

  // ----------------------------------------------------------------------
  // Chain arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ev[i]     = ch_evt[i] & s.ch_cfg[i][CH_IE];
      ev[4 + i] = pp_evt[i] & s.pp_cfg[i][PP_IE];
    end
    src_ip[0] = |s.ip[3:0];
    src_ip[1] = |s.ip[5:4];
    src_ip[2] = |s.ip[7:6];
    pin[0] = 1'h1;
    for (int i = 1; i < NSRC; i++) begin
      pin[i] = pin[i - 1] & ~src_ip[i - 1] & ~s.ius[i - 1];
    end
    req = src_ip & pin & ~s.ius;
    win_any = |req;
    win     = req[0] ? 2'h0 : (req[1] ? 2'h1 : (req[2] ? 2'h2 : 2'h0));
    sub = 2'h3;
    if (win == 2'h0) begin
      for (int i = 3; i >= 0; i--) begin
        if (s.ip[i]) begin
          sub = 2'(i);
        end
      end
    end else begin
      sub = s.ip[{1'h1, win[1], 1'h0}] ? 2'h0 : 2'h1;
    end
    if (win == 2'h0) begin
      win_vec = {s.vbase, sub, 1'h0};
    end else begin
      win_vec = {s.pp_cfg[{win[1], sub[0]}][PP_VEC_LSB +: 7], 1'h0};
    end
  end

  // ----------------------------------------------------------------------
  // Return-from-interrupt snoop
  // ----------------------------------------------------------------------
  // two-byte opcode decode
  assign return_from_interrupt_instruction = FETCH_I && (s.return_from_interrupt_instruction == RD_ED) && (DBUS_I == RETURN_FROM_INTERRUPT_INSTRUCTION_B1);

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  always_comb begin
    rd    = 32'h0000_0000;
    rresp = RESP_OK;
    if (AXI_REQ_I.araddr == ADDR_VBASE) begin
      rd = {24'h00_0000, s.vbase, 3'h0};
    end else if (AXI_REQ_I.araddr == ADDR_STAT) begin
      rd = {10'h000, s.code, 5'h00, s.ius, s.ip};
    end else if (AXI_REQ_I.araddr[7:4] == PAGE_CH) begin
      rd = {8'h00, ch_cnt[AXI_REQ_I.araddr[3:2]],
            s.ch_cfg[AXI_REQ_I.araddr[3:2]]};
    end else if (AXI_REQ_I.araddr[7:4] == PAGE_PCFG) begin
      rd = s.pp_cfg[AXI_REQ_I.araddr[3:2]];
    end else if (AXI_REQ_I.araddr[7:4] == PAGE_PDAT) begin
      rd = {24'h00_0000, pp_data[AXI_REQ_I.araddr[3:2]]};
    end else begin
      rresp = RESP_ERR;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.sync1 = {CNT_I, STB_I, PSTAT_I};
    next_s.sync2 = s.sync1;
    next_s.tick  = (s.div == TMR_DIV_LAST);
    next_s.div   = s.div + 4'h1;
    next_s.nmi_n   = 1'h1;
    next_s.vec_vld = 1'h0;
    clr = 8'h00;
    for (int i = 0; i < 4; i++) begin
      wmask[8 * i +: 8] = {8{s.wstrb[i]}};
    end

    if (IACK_I && win_any) begin
      next_s.vec      = win_vec;
      next_s.vec_vld  = 1'h1;
      next_s.ius[win] = 1'h1;
      next_s.code[win] = sub;
      clr[(win == 2'h0) ? {1'h0, sub} : {1'h1, win[1], sub[0]}] = 1'h1;
    end

    // Innermost nested service is the highest in-service source.
    if (return_from_interrupt_instruction && s.ius != 3'h0) begin
      next_s.ius[s.ius[0] ? 2'h0 : (s.ius[1] ? 2'h1 : 2'h2)] = 1'h0;
    end

    case (s.return_from_interrupt_instruction)
      RD_IDLE: begin
        if (FETCH_I && DBUS_I == RETURN_FROM_INTERRUPT_INSTRUCTION_B0) begin
          next_s.return_from_interrupt_instruction = RD_ED;
        end
      end
      RD_ED: begin
        if (FETCH_I) begin
          next_s.return_from_interrupt_instruction = RD_IDLE;
        end
      end
      default: next_s.return_from_interrupt_instruction = RD_IDLE;
    endcase

    next_s.ip = (s.ip & ~clr) | ev;
    next_s.int_n = ~win_any;

    // Write channel, addresses and data in either order.
    if (AXI_REQ_I.awvalid && s.rsp.awready) begin
      next_s.aw_hold = 1'h1;
      next_s.aw_addr = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && s.rsp.wready) begin
      next_s.w_hold = 1'h1;
      next_s.wdata  = AXI_REQ_I.wdata;
      next_s.wstrb  = AXI_REQ_I.wstrb;
    end
    if (s.rsp.bvalid && AXI_REQ_I.bready) begin
      next_s.rsp.bvalid = 1'h0;
    end
    if (s.aw_hold && s.w_hold && !s.rsp.bvalid) begin
      next_s.aw_hold    = 1'h0;
      next_s.w_hold     = 1'h0;
      next_s.rsp.bvalid = 1'h1;
      next_s.rsp.bresp  = RESP_OK;
      if (s.aw_addr == ADDR_VBASE) begin
        if (s.wstrb[0]) begin
          next_s.vbase = s.wdata[7:3];
        end
      end else if (s.aw_addr[7:4] == PAGE_CH) begin
        next_s.ch_cfg[s.aw_addr[3:2]] =
          (s.ch_cfg[s.aw_addr[3:2]] & ~wmask[15:0])
          | (s.wdata[15:0] & wmask[15:0]);
      end else if (s.aw_addr[7:4] == PAGE_PCFG) begin
        next_s.pp_cfg[s.aw_addr[3:2]] =
          (s.pp_cfg[s.aw_addr[3:2]] & ~wmask) | (s.wdata & wmask);
      end else if (s.aw_addr != ADDR_STAT &&
                   s.aw_addr[7:4] != PAGE_PDAT) begin
        next_s.rsp.bresp = RESP_ERR;
      end
    end
    next_s.rsp.awready = ~next_s.aw_hold & ~next_s.rsp.bvalid;
    next_s.rsp.wready  = ~next_s.w_hold & ~next_s.rsp.bvalid;

    // Read channel, one outstanding read.
    if (s.rsp.rvalid && AXI_REQ_I.rready) begin
      next_s.rsp.rvalid = 1'h0;
    end
    if (AXI_REQ_I.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'h1;
      next_s.rsp.rdata  = rd;
      next_s.rsp.rresp  = rresp;
    end
    next_s.rsp.arready = ~next_s.rsp.rvalid;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s <= '0;
      s.int_n <= 1'h1;
      s.nmi_n <= 1'h1;
      s.ch_cfg <= CH_CFG_RST;
      s.rsp.awready <= 1'h1;
      s.rsp.wready  <= 1'h1;
      s.rsp.arready <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  assign AXI_RSP_O = s.rsp;
  assign INT_N_O   = s.int_n;
  assign NMI_N_O   = s.nmi_n;
  assign VEC_O     = s.vec;
  assign VEC_VLD_O = s.vec_vld;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_vec_even;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      VEC_VLD_O |-> (VEC_O[0] == 1'b0);
  endproperty
  a_vec_even: assert property (p_vec_even)
    else $error("Vector bit zero is set.");
  property p_ack_vec;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (IACK_I && win_any) |=> VEC_VLD_O ##1 !VEC_VLD_O[*1];
  endproperty
  a_ack_vec: assert property (p_ack_vec)
    else $error("Acknowledge gave no one-cycle vector.");
  property p_ctc_vec;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (IACK_I && req[0]) |=>
        (VEC_O == {$past(s.vbase), $past(sub), 1'b0});
  endproperty
  a_ctc_vec: assert property (p_ctc_vec)
    else $error("Counter-timer vector is wrong.");
  property p_no_lower;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (s.ius[0] || src_ip[0]) |-> (req[2:1] == 2'b00);
  endproperty
  a_no_lower: assert property (p_no_lower)
    else $error("Lower source requests over a higher one.");
  property p_top_wins;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (IACK_I && src_ip[0] && !s.ius[0]) |=> s.ius[0];
  endproperty
  a_top_wins: assert property (p_top_wins)
    else $error("Counter-timer lost the acknowledge.");
  property p_return_from_interrupt_instruction_done;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (return_from_interrupt_instruction && s.ius != 3'b000 && !IACK_I) |=>
        (($past(s.ius) & ~s.ius) != 3'b000);
  endproperty
  a_return_from_interrupt_instruction_done: assert property (p_return_from_interrupt_instruction_done)
    else $error("Return did not end a service.");
  property p_nmi_idle;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      NMI_N_O;
  endproperty
  a_nmi_idle: assert property (p_nmi_idle)
    else $error("Non-maskable line was driven.");
  property p_port_a_first;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (IACK_I && req[1] && s.ip[4] && s.ip[5]) |=>
        (VEC_O[7:1] == $past(s.pp_cfg[0][31:25])) && s.ip[5];
  endproperty
  a_port_a_first: assert property (p_port_a_first)
    else $error("Port B served ahead of port A.");
  property p_block_below;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (src_ip[0] || s.ius[0]) |-> !pin[1] && !pin[2];
  endproperty
  a_block_below: assert property (p_block_below)
    else $error("Priority passed a busy source.");
  property p_int_line;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      win_any |=> !INT_N_O;
  endproperty
  a_int_line: assert property (p_int_line)
    else $error("Request did not reach the interrupt line.");

endmodule // dcvi_chain
`default_nettype wire

// file: dv/dcvi_cpu_model.sv
// Processor model: takes vectored interrupts and ends each service.
`default_nettype none
module dcvi_cpu_model
  import dcvi_pkg::*;
#(
  parameter logic [7:0] IBASE = 8'h3C  // Table base byte, arbitrary.
) (
  input  wire logic       clk_i,    // System clock.
  input  wire logic       int_n_i,  // Maskable interrupt, low.
  input  wire logic [7:0] vec_i,    // Supplied vector.
  input  wire logic       vld_i,    // Vector valid pulse.
  output logic            iack_o,   // Acknowledge pulse.
  output logic            fetch_o,  // Opcode fetch strobe.
  output logic      [7:0] dbus_o    // Snooped data bus.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] op;
  logic [7:0] idle;

  initial begin
    iack_o = 1'b0;
    fetch_o = 1'b0;
    op = 8'h00;
    idle = 8'h00;
  end

  // Outside fetches the bus must not look settled, so it toggles.
  always @(posedge clk_i) idle <= ~idle;
  assign dbus_o = fetch_o ? op : idle;

  // Vector is the low byte; even table pointer.
  task automatic take(output logic [15:0] ptr, output bit ok);
    int n;
    ok = 1'b0;
    ptr = 16'h0000;
    for (n = 0; n < 1000 && int_n_i !== 1'b0; n++) @(posedge clk_i);
    if (int_n_i !== 1'b0) return;
    iack_o <= 1'b1;
    @(posedge clk_i);
    iack_o <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge clk_i);
      if (vld_i === 1'b1) begin
        ptr = {IBASE, vec_i};
        ok = 1'b1;
        return;
      end
    end
  endtask

  // Service ends with return from interrupt.
  task automatic return_from_interrupt_instruction();
    fetch_o <= 1'b1;
    op <= RETURN_FROM_INTERRUPT_INSTRUCTION_B0;
    @(posedge clk_i);
    op <= RETURN_FROM_INTERRUPT_INSTRUCTION_B1;
    @(posedge clk_i);
    fetch_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule // dcvi_cpu_model
`default_nettype wire

// file: dv/dcvi_tb.sv
// Self-checking testbench of the interrupt daisy chain.
`default_nettype none
module tb
  import dcvi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] IBASE = 8'h3C;
  logic clk, rst_n, iack, fetch, int_n, nmi_n, vld;
  logic [7:0] dbus, vec;
  logic [3:0] cnt, stb;
  logic [3:0][7:0] pstat;
  dcvi_axi_req_t req;
  dcvi_axi_rsp_t rsp;
  int fail_count = 0;
  int samples_checked = 0;
  logic [1:0] r;
  logic [31:0] d;

  dcvi_chain i_dcvi_chain (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .AXI_REQ_I(req), .AXI_RSP_O(rsp), .IACK_I(iack), .FETCH_I(fetch),
    .DBUS_I(dbus), .CNT_I(cnt), .STB_I(stb), .PSTAT_I(pstat),
    .INT_N_O(int_n), .NMI_N_O(nmi_n), .VEC_O(vec), .VEC_VLD_O(vld));
  dcvi_cpu_model #(.IBASE(IBASE)) i_dcvi_cpu_model (.clk_i(clk),
    .int_n_i(int_n), .vec_i(vec), .vld_i(vld), .iack_o(iack),
    .fetch_o(fetch), .dbus_o(dbus));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic axi(input bit wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    if (wr) begin
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= wd;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
    end else begin
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (wr && rsp.bvalid === 1'b1) break;
      if (!wr && rsp.rvalid === 1'b1) break;
    end
    r = wr ? rsp.bresp : rsp.rresp;
    d = rsp.rdata;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    if (n == 50) begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic take(input string nm, input logic [7:0] exp);
    logic [15:0] p;
    bit ok;
    i_dcvi_cpu_model.take(p, ok);
    if (!ok) begin
      fail_count++;
      end_sim();
    end
    chk(nm, {16'h0000, IBASE, exp}, {16'h0000, p});
  endtask

  task automatic pins(input logic [3:0] s, c);
    stb <= s;
    cnt <= c;
    repeat (4) @(posedge clk);
    stb <= 4'h0;
    cnt <= 4'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs();
    chk("nmi", 32'h1, {31'h0, nmi_n});
    chk("int", 32'h1, {31'h0, int_n});
    axi(1'b1, ADDR_VBASE, 32'h0000_00A8);
    chk("wresp", {30'h0, RESP_OK}, {30'h0, r});
    axi(1'b0, ADDR_VBASE, 32'h0);
    chk("vbase", 32'h0000_00A8, d & 32'h0000_00F8);
    axi(1'b0, 8'h08, 32'h0);
    chk("unmapped", {30'h0, RESP_ERR}, {30'h0, r});
    axi(1'b1, 8'h18, 32'h0000_0107);
    axi(1'b1, 8'h20, 32'h2000_0005);
    axi(1'b1, 8'h24, 32'h2200_0005);
    axi(1'b1, 8'h28, 32'h4000_0005);
    axi(1'b1, 8'h2C, 32'h865A_FF07);
    $display("regs done");
  endtask

  // Channel 2 counts edges; channels 0, 1, 3 time the clock.
  task automatic t_chan();
    pins(4'h0, 4'h4);
    take("ch2 vec", 8'hAC);
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    for (int c = 0; c < 4; c++) begin
      if (c == 2) continue;
      axi(1'b1, 8'h10 + 8'(4 * c), 32'h0000_1003);
      take("timer vec", {5'h15, 2'(c), 1'b0});
      axi(1'b1, 8'h10 + 8'(4 * c), 32'h0000_0000);
      i_dcvi_cpu_model.return_from_interrupt_instruction();
    end
    $display("channels done");
  endtask

  task automatic t_prio();
    pins(4'h3, 4'h4);
    take("first ct", 8'hAC);
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    take("then a", 8'h20);
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    take("then b", 8'h22);
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    $display("priority done");
  endtask

  task automatic t_nest();
    pstat[0] <= 8'h3C;
    pins(4'h1, 4'h0);
    take("kbd a", 8'h20);
    axi(1'b0, 8'h30, 32'h0);
    chk("kbd byte", 32'h0000_003C, d);
    pins(4'h0, 4'h4);
    take("nested ct", 8'hAC);
    axi(1'b0, ADDR_STAT, 32'h0);
    chk("in service", 32'h0002_0300, d & 32'h0003_0700);
    pins(4'h4, 4'h0);
    repeat (10) @(posedge clk);
    chk("blocked", 32'h1, {31'h0, int_n});
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    repeat (10) @(posedge clk);
    chk("still blocked", 32'h1, {31'h0, int_n});
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    take("printer a", 8'h40);
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    $display("nesting done");
  endtask

  task automatic t_bit();
    pstat[3] <= 8'h5A;
    take("bit match", 8'h86);
    i_dcvi_cpu_model.return_from_interrupt_instruction();
    pstat[3] <= 8'h00;
    repeat (10) @(posedge clk);
    chk("no match", 32'h1, {31'h0, int_n});
    $display("bit mode done");
  endtask

  initial begin
    rst_n = 1'b0;
    req = '0;
    cnt = 4'h0;
    stb = 4'h0;
    pstat = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_chan();
    t_prio();
    t_nest();
    t_bit();
    end_sim();
  end
endmodule // tb
`default_nettype wire
